// ---- rtl/pwrq_core_end.sv ----
// Bus core end: wide request pin control, registered cycle signals,
// address latch and core drive of the internal multiplexed bus.
// Assumes PCI pins are synchronous to clk; FRAME and IRDY are driven by the
// rest of the core, this block only watches them.
//
// What this block does
// - Hold wide request whole transfer, drop at last phase
// - Start only after grant held over one cycle
// - Start only while frame and initiator ready idle
// - Start only with master enable bit set
// - User asks wide transfer; core starts only then
// - User completion input ends wide request
// - Retry, disconnect or target abort ends request
// - No claim means master abort, end request
// - Expired enabled latency timer plus lost grant ends
// - Claim without wide acknowledge ends request
// - Outside module drives static 256-bit configuration
// - Registered active-low copies of five bus signals
// - Latch address; valid after strobe until next
// - Internal bus driven only through enabled buffers
// - Strobe potential target address phases, not own
`timescale 1ns/1ps
module pwrq_core_end (
	input  wire logic                        clk,
	input  wire logic                        rst_n,
	input  wire logic                        gnt_n,
	input  wire logic                        frame_n,
	input  wire logic                        initiator_ready_pin,
	input  wire logic                        target_claim_pin,
	input  wire logic                        target_ready_pin,
	input  wire logic                        stop_n,
	input  wire logic                        ack64_n,
	input  wire logic [pwrq_pkg::ADDR_W-1:0] ad_in,
	input  wire logic                        wide_request_pin_in,
	output logic                             wide_request_pin_out,
	output logic                             wide_request_pin_oe_n,
	pwrq_user_if.core                        uif
);

	////////////////////////////////////////////////////////////////////////
	// Grant history and start conditions

	pwrq_pkg::pwrq_state_t state;
	pwrq_pkg::pwrq_state_t next_state;
	logic                  gnt_prev_n;
	logic                  gnt_long;
	logic                  bus_idle;
	logic                  start_ok;
	logic                  end_now;
	logic                  lat_expired;
	logic [pwrq_pkg::LAT_W-1:0]       lat_count;
	logic [pwrq_pkg::CLAIM_CNT_W-1:0] claim_count;
	logic                  no_claim;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gnt_prev_n <= pwrq_pkg::PIN_IDLE;
		end else begin
			gnt_prev_n <= gnt_n;
		end
	end

	assign gnt_long = !gnt_n && !gnt_prev_n;
	assign bus_idle = frame_n && initiator_ready_pin;
	// Pin reads back its own level, so another wide initiator blocks us too
	assign start_ok = gnt_long && bus_idle && wide_request_pin_in
	                  && uif.master_enable_bit
	                  && uif.user_wide_transfer_ask;

	////////////////////////////////////////////////////////////////////////
	// Latency timer and claim watchdog

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lat_count <= pwrq_pkg::LAT_RESET;
		end else if (state == pwrq_pkg::PWRQ_IDLE) begin
			lat_count <= pwrq_pkg::LAT_RESET;
		end else if (lat_count != {pwrq_pkg::LAT_W{1'b1}}) begin
			lat_count <= lat_count + 8'h01;
		end
	end

	assign lat_expired = uif.latency_timer_on && (lat_count >= uif.latency_limit);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			claim_count <= pwrq_pkg::CLAIM_RESET;
		end else if (state == pwrq_pkg::PWRQ_CLAIM) begin
			claim_count <= claim_count + 3'h1;
		end else begin
			claim_count <= pwrq_pkg::CLAIM_RESET;
		end
	end

	assign no_claim = (state == pwrq_pkg::PWRQ_CLAIM) && target_claim_pin
	                  && (claim_count == pwrq_pkg::CLAIM_CNT_W'(pwrq_pkg::CLAIM_WAIT - 1));

	// Any of these makes the current phase the last one
	assign end_now = uif.complete
	                 || !stop_n
	                 || no_claim
	                 || (lat_expired && gnt_n)
	                 || (!target_claim_pin && ack64_n);

	////////////////////////////////////////////////////////////////////////
	// Wide request sequencer

	always_comb begin
		next_state = state;
		case (state)
			pwrq_pkg::PWRQ_IDLE: begin
				if (start_ok) begin
					next_state = pwrq_pkg::PWRQ_ADDR;
				end
			end
			pwrq_pkg::PWRQ_ADDR: begin
				next_state = uif.complete ? pwrq_pkg::PWRQ_END : pwrq_pkg::PWRQ_CLAIM;
			end
			pwrq_pkg::PWRQ_CLAIM: begin
				if (end_now) begin
					next_state = pwrq_pkg::PWRQ_END;
				end else if (!target_claim_pin) begin
					next_state = pwrq_pkg::PWRQ_DATA;
				end
			end
			pwrq_pkg::PWRQ_DATA: begin
				if (end_now) begin
					next_state = pwrq_pkg::PWRQ_END;
				end
			end
			pwrq_pkg::PWRQ_END: begin
				next_state = pwrq_pkg::PWRQ_IDLE;
			end
			default: begin
				next_state = pwrq_pkg::PWRQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= pwrq_pkg::PWRQ_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Low in every state of the transfer, high in the last-phase state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wide_request_pin_out  <= pwrq_pkg::PIN_IDLE;
			wide_request_pin_oe_n <= 1'b1;
		end else begin
			wide_request_pin_out  <= !(next_state == pwrq_pkg::PWRQ_ADDR
			                        || next_state == pwrq_pkg::PWRQ_CLAIM
			                        || next_state == pwrq_pkg::PWRQ_DATA);
			// Sustained three-state: one driven-high clock before release
			wide_request_pin_oe_n <= (next_state == pwrq_pkg::PWRQ_IDLE);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			uif.wide_master_abort <= 1'b0;
		end else begin
			uif.wide_master_abort <= no_claim;
		end
	end

	assign uif.wide_active = (state != pwrq_pkg::PWRQ_IDLE);

	////////////////////////////////////////////////////////////////////////
	// Registered cycle signals, address strobe and latch

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			uif.frame_registered_copy      <= pwrq_pkg::PIN_IDLE;
			uif.claim_registered_copy      <= pwrq_pkg::PIN_IDLE;
			uif.init_ready_registered_copy <= pwrq_pkg::PIN_IDLE;
			uif.targ_ready_registered_copy <= pwrq_pkg::PIN_IDLE;
			uif.stop_registered_copy       <= pwrq_pkg::PIN_IDLE;
		end else begin
			uif.frame_registered_copy      <= frame_n;
			uif.claim_registered_copy      <= target_claim_pin;
			uif.init_ready_registered_copy <= initiator_ready_pin;
			uif.targ_ready_registered_copy <= target_ready_pin;
			uif.stop_registered_copy       <= stop_n;
		end
	end

	// Falling frame while our sequencer is idle is someone else's address
	assign uif.cycle_start_strobe = !frame_n && uif.frame_registered_copy
	                                && (state == pwrq_pkg::PWRQ_IDLE);

	// Core drives the shared bus only in the strobe cycle, via its enable
	assign uif.core_bus_out  = ad_in;
	assign uif.core_bus_oe_n = !uif.cycle_start_strobe;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			uif.latched_address <= pwrq_pkg::ADDR_RESET;
		end else if (uif.cycle_start_strobe) begin
			uif.latched_address <= uif.internal_muxed_bus;
		end
	end

endmodule // pwrq_core_end

// ---- rtl/pwrq_pkg.sv ----
// Shared constants for the wide request and user cycle port.
// Assumes one PCI clock domain; both ends and the interface use these names.
package pwrq_pkg;
	localparam int          ADDR_W          = 32;
	localparam int          CFG_W           = 256;
	localparam int          LAT_W           = 8;
	// Grant must be seen low on this many consecutive edges before a start
	localparam int          GNT_HOLD_CYCLES = 2;
	// Clocks after the address phase allowed for a claim before master abort
	localparam int          CLAIM_WAIT      = 5;
	localparam int          CLAIM_CNT_W     = 3;
	localparam logic        PIN_IDLE        = 1'b1;
	localparam logic [31:0] ADDR_RESET      = 32'h0000_0000;
	localparam logic [7:0]  LAT_RESET       = 8'h00;
	localparam logic [2:0]  CLAIM_RESET     = 3'h0;

	typedef enum logic [2:0] {
		PWRQ_IDLE,
		PWRQ_ADDR,
		PWRQ_CLAIM,
		PWRQ_DATA,
		PWRQ_END
	} pwrq_state_t;
endpackage

// ---- rtl/pwrq_user_if.sv ----
// Interface joining the bus core end and the user application end.
// Assumes both ends run on the same PCI clock; the shared internal bus is
// resolved here from the two output enables (active low).
`timescale 1ns/1ps
interface pwrq_user_if;
	logic [pwrq_pkg::CFG_W-1:0]  cfg;
	logic                        user_wide_transfer_ask;
	logic                        complete;
	logic                        master_enable_bit;
	logic                        latency_timer_on;
	logic [pwrq_pkg::LAT_W-1:0]  latency_limit;
	logic                        frame_registered_copy;
	logic                        claim_registered_copy;
	logic                        init_ready_registered_copy;
	logic                        targ_ready_registered_copy;
	logic                        stop_registered_copy;
	logic                        cycle_start_strobe;
	logic [pwrq_pkg::ADDR_W-1:0] latched_address;
	logic                        wide_master_abort;
	logic                        wide_active;
	logic [pwrq_pkg::ADDR_W-1:0] core_bus_out;
	logic                        core_bus_oe_n;
	logic [pwrq_pkg::ADDR_W-1:0] user_bus_out;
	logic                        user_bus_oe_n;
	logic [pwrq_pkg::ADDR_W-1:0] internal_muxed_bus;

	// Stands in for the internal three-state buffers; nobody driving reads zero
	assign internal_muxed_bus = !core_bus_oe_n ? core_bus_out :
	                            !user_bus_oe_n ? user_bus_out : '0;

	modport core (
		input  cfg, user_wide_transfer_ask, complete, master_enable_bit,
		input  latency_timer_on, latency_limit, user_bus_out, user_bus_oe_n,
		input  internal_muxed_bus,
		output frame_registered_copy, claim_registered_copy,
		output init_ready_registered_copy, targ_ready_registered_copy,
		output stop_registered_copy, cycle_start_strobe, latched_address,
		output wide_master_abort, wide_active, core_bus_out, core_bus_oe_n
	);

	modport app (
		output cfg, user_wide_transfer_ask, complete, master_enable_bit,
		output latency_timer_on, latency_limit, user_bus_out, user_bus_oe_n,
		input  internal_muxed_bus,
		input  frame_registered_copy, claim_registered_copy,
		input  init_ready_registered_copy, targ_ready_registered_copy,
		input  stop_registered_copy, cycle_start_strobe, latched_address,
		input  wide_master_abort, wide_active, core_bus_out, core_bus_oe_n
	);
endinterface

// ---- rtl/pwrq_app_end.sv ----
// User application end: static configuration vector, wide transfer
// controls and the user's buffered drive of the internal bus.
// Assumes the application holds its ask until it signals the last transfer.
`timescale 1ns/1ps
module pwrq_app_end #(
	parameter logic [pwrq_pkg::CFG_W-1:0] CFG_VALUE = '0
) (
	input  wire logic                        clk,
	input  wire logic                        rst_n,
	input  wire logic                        app_wide_ask,
	input  wire logic                        app_last,
	input  wire logic                        app_master_enable,
	input  wire logic                        app_latency_on,
	input  wire logic [pwrq_pkg::LAT_W-1:0]  app_latency_limit,
	input  wire logic [pwrq_pkg::ADDR_W-1:0] app_bus_data,
	input  wire logic                        app_bus_drive,
	output logic [pwrq_pkg::ADDR_W-1:0]      app_bus_read,
	output logic [pwrq_pkg::ADDR_W-1:0]      app_address,
	output logic                             app_address_new,
	pwrq_user_if.app                         uif
);

	assign uif.cfg = CFG_VALUE;
	assign uif.user_wide_transfer_ask = app_wide_ask;
	assign uif.complete = app_last;
	assign uif.master_enable_bit = app_master_enable;
	assign uif.latency_timer_on = app_latency_on;
	assign uif.latency_limit = app_latency_limit;

	////////////////////////////////////////////////////////////////////////
	// Shared bus: yield whenever the core enables its buffer

	assign uif.user_bus_out  = app_bus_data;
	assign uif.user_bus_oe_n = !(app_bus_drive && uif.core_bus_oe_n);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			app_bus_read    <= pwrq_pkg::ADDR_RESET;
			app_address     <= pwrq_pkg::ADDR_RESET;
			app_address_new <= 1'b0;
		end else begin
			app_bus_read    <= uif.internal_muxed_bus;
			app_address     <= uif.latched_address;
			app_address_new <= uif.cycle_start_strobe;
		end
	end

endmodule // pwrq_app_end

// ---- testbench/pwrq_props.sv ----
// Concurrent checks on the wide request pin and the user cycle signals.
// Assumes the bench top wires it beside the interface; one clock domain.
`timescale 1ns/1ps
module pwrq_props (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        gnt_n,
	input wire logic        frame_n,
	input wire logic        initiator_ready_pin,
	input wire logic        target_claim_pin,
	input wire logic        stop_n,
	input wire logic        ack64_n,
	input wire logic        wide_request_pin_out,
	input wire logic        wide_request_pin_oe_n,
	input wire logic        complete,
	input wire logic        master_enable_bit,
	input wire logic        user_wide_transfer_ask,
	input wire logic        frame_registered_copy,
	input wire logic        claim_registered_copy,
	input wire logic        cycle_start_strobe,
	input wire logic [31:0] latched_address,
	input wire logic        wide_active,
	input wire logic [31:0] core_bus_out,
	input wire logic        core_bus_oe_n,
	input wire logic [31:0] internal_muxed_bus
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Cycles the request has stood low without a claim; a hung sequencer shows here
	logic [3:0] wait_cnt;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			wait_cnt <= 4'h0;
		else if (!wide_request_pin_out && !wide_request_pin_oe_n && target_claim_pin)
			wait_cnt <= wait_cnt + 4'h1;
		else
			wait_cnt <= 4'h0;
	end
	////////////////////////////////////////////////////////////////////////////////
	a_start_grant_held: assert property ($fell(wide_request_pin_out) |->
		!$past(gnt_n) && !$past(gnt_n, 2)) else $error("start without held grant");
	a_start_bus_idle: assert property ($fell(wide_request_pin_out) |->
		$past(frame_n) && $past(initiator_ready_pin)) else $error("start on busy bus");
	a_start_when_asked: assert property ($fell(wide_request_pin_out) |->
		$past(master_enable_bit) && $past(user_wide_transfer_ask)) else $error("start unasked");
	a_complete_ends: assert property ((!wide_request_pin_out && complete) |=>
		wide_request_pin_out && !wide_request_pin_oe_n) else $error("complete ignored");
	a_stop_ends: assert property ((!wide_request_pin_out && !$past(wide_request_pin_out)
		&& !stop_n) |=> wide_request_pin_out) else $error("stop ignored");
	a_narrow_claim_ends: assert property ((!wide_request_pin_out
		&& !$past(wide_request_pin_out) && !target_claim_pin && ack64_n)
		|=> wide_request_pin_out) else $error("narrow claim ignored");
	a_claim_wait_bound: assert property (wait_cnt < 4'h8)
		else $error("no master abort");
	a_release_after_high: assert property (($rose(wide_request_pin_out)
		&& !wide_request_pin_oe_n) |=> wide_request_pin_oe_n) else $error("not released");
	a_copy_delay: assert property (frame_registered_copy == $past(frame_n)
		&& claim_registered_copy == $past(target_claim_pin)) else $error("copy late");
	a_addr_latch: assert property (cycle_start_strobe |=>
		latched_address == $past(core_bus_out)) else $error("address not latched");
	a_addr_hold: assert property (!cycle_start_strobe |=> $stable(latched_address))
		else $error("address moved");
	a_strobe_idle: assert property (cycle_start_strobe |->
		!frame_n && frame_registered_copy && !wide_active) else $error("bad strobe");
	a_core_drive: assert property (cycle_start_strobe |->
		!core_bus_oe_n && internal_muxed_bus == core_bus_out) else $error("bus not driven");
	c_start: cover property ($fell(wide_request_pin_out));
	c_strobe: cover property (cycle_start_strobe);
	c_long_wait: cover property (wait_cnt == 4'h5);
endmodule // pwrq_props

// ---- testbench/pci_wide_request_and_user_cycle_port_test.sv ----
// Bench joining the core end and the application end through the interface.
// Assumes the bench plays arbiter, targets and the rest of the core's pins.
`timescale 1ns/1ps
module pci_wide_request_and_user_cycle_port_test;
	localparam logic [255:0] CFG = {8{32'hA5C3_0F1E}};
	logic        clk, rst_n, gnt_n, frame_n, initiator_ready_pin, target_claim_pin;
	logic        target_ready_pin, stop_n, ack64_n, app_wide_ask, app_last;
	logic        app_master_enable, app_latency_on, app_bus_drive, abort_seen;
	logic        wide_request_pin_out, wide_request_pin_oe_n, app_address_new;
	logic [7:0]  app_latency_limit;
	logic [31:0] ad_in, app_bus_data, rnd, app_bus_read, app_address;
	int          bad_count, checked;
	// Pull-up on the released pin
	wire         wide_request_pin_in = wide_request_pin_oe_n ? 1'b1 : wide_request_pin_out;
	pwrq_user_if uif ();
	pwrq_core_end u_pwrq_core_end (.clk, .rst_n, .gnt_n, .frame_n, .initiator_ready_pin,
		.target_claim_pin, .target_ready_pin, .stop_n, .ack64_n, .ad_in, .wide_request_pin_in,
		.wide_request_pin_out, .wide_request_pin_oe_n, .uif(uif));
	pwrq_app_end #(.CFG_VALUE(CFG)) u_pwrq_app_end (.clk, .rst_n, .app_wide_ask, .app_last,
		.app_master_enable, .app_latency_on, .app_latency_limit, .app_bus_data, .app_bus_drive,
		.app_bus_read, .app_address, .app_address_new, .uif(uif));
	pwrq_props u_pwrq_props (.clk, .rst_n, .gnt_n, .frame_n, .initiator_ready_pin,
		.target_claim_pin, .stop_n, .ack64_n, .wide_request_pin_out, .wide_request_pin_oe_n,
		.complete(uif.complete), .master_enable_bit(uif.master_enable_bit),
		.user_wide_transfer_ask(uif.user_wide_transfer_ask),
		.frame_registered_copy(uif.frame_registered_copy),
		.claim_registered_copy(uif.claim_registered_copy),
		.cycle_start_strobe(uif.cycle_start_strobe), .latched_address(uif.latched_address),
		.wide_active(uif.wide_active), .core_bus_out(uif.core_bus_out),
		.core_bus_oe_n(uif.core_bus_oe_n), .internal_muxed_bus(uif.internal_muxed_bus));
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) if (uif.wide_master_abort === 1'b1) abort_seen <= 1'b1;
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	function automatic logic exp_abort(input int kind);
		return kind == 3;
	endfunction
	task automatic summarize;
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk_bit(input string what, input logic exp, input logic got);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wait_pin(input logic v);
		for (int n = 0; !(wide_request_pin_out === v && wide_request_pin_oe_n === 1'b0); n++) begin
			if (n > 20) begin
				// A timeout always counts, even if the level happens to match
				bad_count++;
				$display("mismatch wait request pin expected %b seen %b", v, wide_request_pin_out);
				summarize();
			end
			@(posedge clk);
			#1;
		end
	endtask
	// Kinds: 0 complete, 1 stop, 2 narrow claim, 3 no claim, 4 latency expiry
	task automatic xfer(input int kind);
		@(posedge clk);
		rnd = xs(rnd);
		ad_in <= rnd;
		gnt_n <= 1'b0;
		app_wide_ask <= 1'b1;
		app_latency_on <= kind == 4;
		abort_seen <= 1'b0;
		wait_pin(1'b0);
		chk_bit("active", 1'b1, uif.wide_active);
		@(posedge clk);
		target_claim_pin <= kind == 3;
		ack64_n <= kind == 2;
		gnt_n <= kind == 4;
		stop_n <= kind != 1;
		app_last <= kind == 0;
		wait_pin(1'b1);
		chk_bit("ended high", 1'b1, wide_request_pin_out);
		@(posedge clk);
		{target_claim_pin, ack64_n, stop_n, gnt_n} <= 4'hF;
		{app_last, app_wide_ask} <= 2'h0;
		#1;
		chk_bit("released", 1'b1, wide_request_pin_oe_n);
		chk_bit("idle again", 1'b0, uif.wide_active);
		chk_bit("master abort", exp_abort(kind), abort_seen);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{rst_n, app_wide_ask, app_last, app_latency_on, app_bus_drive, abort_seen} = 6'h00;
		{gnt_n, frame_n, initiator_ready_pin, target_claim_pin} = 4'hF;
		{target_ready_pin, stop_n, ack64_n, app_master_enable} = 4'hF;
		{bad_count, checked} = 0;
		app_latency_limit = 8'h02;
		ad_in = 32'h0000_0000;
		app_bus_data = 32'h0000_0000;
		rnd = 32'h0000_0034;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk_bit("cfg", 1'b1, uif.cfg === CFG);
		chk_bit("reset release", 1'b1, wide_request_pin_oe_n);
		for (int r = 0; r < 4; r++) begin
			for (int c = 0; c < 6; c++) begin
				@(posedge clk);
				gnt_n <= r == 3 ? !c[0] : 1'b0;
				app_master_enable <= r != 0;
				app_wide_ask <= r != 1;
				initiator_ready_pin <= r != 2;
				#1;
				chk_bit("refused", 1'b1, wide_request_pin_oe_n);
			end
		end
		@(posedge clk);
		{gnt_n, initiator_ready_pin, app_wide_ask} <= 3'h6;
		for (int k = 0; k < 10; k++) xfer(k % 5);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			rnd = xs(rnd);
			frame_n <= 1'b0;
			ad_in <= rnd;
			app_bus_data <= ~rnd;
			app_bus_drive <= 1'b1;
			{initiator_ready_pin, target_claim_pin, target_ready_pin, stop_n} <= rnd[3:0];
			#1;
			chk_bit("strobe", 1'b1, uif.cycle_start_strobe);
			chk_word("core bus", rnd, uif.internal_muxed_bus);
			@(posedge clk);
			frame_n <= 1'b1;
			#1;
			chk_word("address", rnd, uif.latched_address);
			chk_word("user bus", ~rnd, uif.internal_muxed_bus);
			chk_word("copies", {28'h0, rnd[3:0]}, {27'h0, uif.frame_registered_copy,
				uif.init_ready_registered_copy, uif.claim_registered_copy,
				uif.targ_ready_registered_copy, uif.stop_registered_copy});
			chk_word("user read", rnd, app_bus_read);
			chk_bit("address new", 1'b1, app_address_new);
			@(posedge clk);
			#1;
			chk_word("user address", rnd, app_address);
			chk_bit("address new end", 1'b0, app_address_new);
		end
		summarize();
	end
endmodule // pci_wide_request_and_user_cycle_port_test
